// File: pkg/csx_pkg.sv
// Constants for the clocked serial engine: register map, fields, resets, timing.
// Assumes a 40 MHz system clock and a 32-bit Avalon-MM register port.
package csx_pkg;
	// Clock and internal serial clock rate
	localparam int CLK_KHZ = 40000;
	localparam int SCK_INT_KBPS = 625;
	localparam int SCK_HALF_CYC = CLK_KHZ / (2 * SCK_INT_KBPS);
	localparam int DIV_W = 6;
	localparam logic [DIV_W-1:0] HALF_LAST = DIV_W'(SCK_HALF_CYC - 1);
	localparam logic [DIV_W-1:0] LOW_PULSE_CYC = DIV_W'(SCK_HALF_CYC);
	localparam logic [3:0] CHAR_BITS = 4'h8;
	localparam logic [3:0] LAST_BIT_IDX = 4'h7;

	// Register byte offsets
	localparam int ADDR_W = 5;
	localparam logic [ADDR_W-1:0] OFS_HMODE = 5'h00;
	localparam logic [ADDR_W-1:0] OFS_LMODE = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_MASK = 5'h08;
	localparam logic [ADDR_W-1:0] OFS_TXBUF = 5'h0c;
	localparam logic [ADDR_W-1:0] OFS_RXBUF = 5'h10;
	localparam logic [ADDR_W-1:0] OFS_STAT = 5'h14;

	// serial_high_mode_register fields
	localparam int HM_TXE = 0;
	localparam int HM_RXE = 1;
	localparam int HM_SE = 2;
	localparam int HM_SK1 = 3;
	localparam int HM_SK2 = 4;
	localparam int HM_TSK = 5;
	// serial_low_mode_register field: 1 selects I/O interface mode
	localparam int LM_IO = 0;
	// interrupt_mask_register fields
	localparam int MK_RX = 0;
	localparam int MK_TX = 1;
	// Status fields
	localparam int ST_TXREQ = 0;
	localparam int ST_RXREQ = 1;
	localparam int ST_TXF = 2;
	localparam int ST_RXF = 3;
	localparam int ST_TXFULL = 4;
	localparam int ST_TXBUSY = 5;

	// Reset values
	localparam logic [4:0] HMODE_RST = 5'h00;
	localparam logic LMODE_RST = 1'b0;
	localparam logic [1:0] MASK_RST = 2'h3;
	localparam logic [7:0] BYTE_RST = 8'h00;
endpackage

// File: pkg/csx_edge_if.sv
// Carrier for synchronised serial clock edges and receive data.
// Assumes producer and consumer share clk_sys_i.
`timescale 1ns/1ps
interface csx_edge_if;
	logic sck_rise;
	logic sck_fall;
	logic rxd;
	modport src (output sck_rise, output sck_fall, output rxd);
	modport dst (input sck_rise, input sck_fall, input rxd);
endinterface

// File: core/csx_pin_sync.sv
// Two-stage synchronisers for the serial clock and receive data pins.
// Assumes both pins are asynchronous to clk_sys_i.
`timescale 1ns/1ps
module csx_pin_sync
	import csx_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic sck_i,
	input wire logic rxd_i,
	csx_edge_if.src edge_o
);
	logic sck_meta;
	logic sck_sync;
	logic sck_prev;
	logic rxd_meta;
	logic rxd_sync;

	// Idle level of the line is high
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			sck_meta <= 1'b1;
			sck_sync <= 1'b1;
			sck_prev <= 1'b1;
			rxd_meta <= 1'b1;
			rxd_sync <= 1'b1;
		end else begin
			sck_meta <= sck_i;
			sck_sync <= sck_meta;
			sck_prev <= sck_sync;
			rxd_meta <= rxd_i;
			rxd_sync <= rxd_meta;
		end
	end

	assign edge_o.sck_rise = sck_sync & ~sck_prev;
	assign edge_o.sck_fall = ~sck_sync & sck_prev;
	assign edge_o.rxd = rxd_sync;
endmodule

// File: core/csx_serial.sv
// Clocked serial engine: synchronous mode and I/O interface mode, Avalon-MM slave.
// Assumes external serial clock and receive data are asynchronous pins.
//
// Behaviour
// RL1: Synchronous reception only while receive enable set; sample on rising clock.
// RL2: Search mode stores to receive buffer and interrupts after every bit.
// RL3: No hardware sync-character detection; software clears search enable.
// RL4: Character mode stores and interrupts once per eight received bits.
// RL5: Reception mask bit suppresses reception interrupt in every mode.
// RL6: Internal clock 625 kbps; external clock up to 1.25 Mbps.
// RL7: I/O interface mode uses fixed eight-bit characters without parity.
// RL8: I/O mode sends MSB-first on falling edge, samples on rising.
// RL9: Internal clock gives eight-pulse burst when transmit data loads.
// RL10: External partner gives exactly eight pulses, clock high when idle.
// RL11: Transmit only with transmit enable; buffer loads after previous transfer.
// RL12: Empty transmit buffer raises transmission interrupt unless masked.
// RL13: I/O reception stores eight MSB-first bits and raises reception interrupt.
// RL14: Internal clock receive-only burst starts on clock trigger write.
// RL15: External reception at most 660 kbps; eighth pulse high six states.
// RL16: Transmit-to-receive switch in I/O mode emits one low pulse.
// RL17: Short external transfer finishes on internal clock; sets transmit flag.
// RL18: Receive recovery: trigger finishes remaining pulses then sets receive flag.
// RL19: Both clock selects high is external; exactly one high is internal.
// RL20: Synchronous mode sends eight bits LSB-first on falling edge.
// RL21: Transmit line holds mark level when disabled or nothing to send.
// RL22: Reset clears transmit and receive enable; engine stays idle.
`timescale 1ns/1ps
module csx_serial
	import csx_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic [ADDR_W-1:0] address_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic [31:0] writedata_i,
	output logic [31:0] readdata_o,
	output logic waitrequest_o,
	input wire logic sck_i,
	input wire logic rxd_i,
	output logic sck_o,
	output logic sck_oe_o,
	output logic txd_o,
	output logic irq_tx_o,
	output logic irq_rx_o
);
	csx_edge_if pin_edge ();

	csx_pin_sync u_sync (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.sck_i(sck_i),
		.rxd_i(rxd_i),
		.edge_o(pin_edge)
	);

	logic transmit_enable_bit, receive_enable_bit, se, sk1, sk2, io_mode;
	logic mask_rx, mask_tx;
	logic [7:0] txb, rxb, tx_sh, rx_sh;
	logic tx_full, tx_active;
	logic [3:0] tx_cnt, rx_cnt;
	logic rx_run;
	logic tx_req, rx_req, tx_flag, rx_flag;
	logic txe_q;
	logic [DIV_W-1:0] low_cnt, div_cnt;
	logic sck_int;
	logic [3:0] burst_pulses;

	// Bus strobes
	logic acc, wr, rd;
	assign acc = (read_i | write_i) & ~waitrequest_o;
	assign wr = acc & write_i;
	assign rd = acc & read_i;
	logic wr_hm, wr_lm, wr_mk, wr_tx, wr_st, rd_rx, tsk_wr;
	assign wr_hm = wr && address_i == OFS_HMODE;
	assign wr_lm = wr && address_i == OFS_LMODE;
	assign wr_mk = wr && address_i == OFS_MASK;
	assign wr_tx = wr && address_i == OFS_TXBUF;
	assign wr_st = wr && address_i == OFS_STAT;
	assign rd_rx = rd && address_i == OFS_RXBUF;
	assign tsk_wr = wr_hm & writedata_i[HM_TSK];

	// Clock source
	logic ext_sel, int_sel;
	assign ext_sel = sk1 & sk2; // RL19
	assign int_sel = sk1 ^ sk2; // RL19

	// Internal clock: free-running in synchronous mode, bursts in I/O mode
	logic run_int, int_active, int_tick, int_rise, int_fall;
	assign run_int = int_sel & (io_mode ? ((transmit_enable_bit & tx_active) | rx_run) : (transmit_enable_bit | receive_enable_bit));
	// A started low phase always completes so bursts end high
	assign int_active = run_int | ~sck_int;
	assign int_tick = int_active && div_cnt == HALF_LAST; // RL6
	assign int_fall = int_tick & sck_int;
	assign int_rise = int_tick & ~sck_int;

	logic rise_e, fall_e;
	assign rise_e = ext_sel ? pin_edge.sck_rise : int_rise;
	assign fall_e = ext_sel ? pin_edge.sck_fall : int_fall;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			div_cnt <= '0;
			sck_int <= 1'b1;
		end else if (!int_active) begin
			div_cnt <= '0;
		end else if (int_tick) begin
			div_cnt <= '0;
			sck_int <= ~sck_int;
		end else begin
			div_cnt <= div_cnt + 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			sck_o <= 1'b1;
			sck_oe_o <= 1'b0;
		end else begin
			sck_o <= sck_int;
			sck_oe_o <= int_sel; // RL9
		end
	end

	// Mode registers
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			{sk2, sk1, se, receive_enable_bit, transmit_enable_bit} <= HMODE_RST; // RL22
			io_mode <= LMODE_RST;
			{mask_tx, mask_rx} <= MASK_RST;
		end else begin
			if (wr_hm) begin
				transmit_enable_bit <= writedata_i[HM_TXE];
				receive_enable_bit <= writedata_i[HM_RXE];
				se <= writedata_i[HM_SE]; // RL3
				sk1 <= writedata_i[HM_SK1];
				sk2 <= writedata_i[HM_SK2];
			end
			if (wr_lm) begin
				io_mode <= writedata_i[LM_IO];
			end
			if (wr_mk) begin
				mask_rx <= writedata_i[MK_RX];
				mask_tx <= writedata_i[MK_TX];
			end
		end
	end

	// Transmit path; a stalled partial transfer keeps its count for recovery
	logic tx_load, tx_step_rise, tx_step_fall, tx_done;
	assign tx_load = transmit_enable_bit & tx_full & ~tx_active; // RL11
	assign tx_step_fall = transmit_enable_bit & tx_active & fall_e;
	assign tx_step_rise = transmit_enable_bit & tx_active & rise_e;
	assign tx_done = tx_step_rise && tx_cnt == 4'h1;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			txb <= BYTE_RST;
			tx_full <= 1'b0;
		end else if (wr_tx) begin
			// Overwrites an unsent byte; software checks the request flag first
			txb <= writedata_i[7:0];
			tx_full <= 1'b1;
		end else if (tx_load) begin
			tx_full <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			tx_sh <= BYTE_RST;
			tx_active <= 1'b0;
			tx_cnt <= 4'h0;
		end else if (tx_load) begin
			tx_sh <= txb;
			tx_active <= 1'b1;
			tx_cnt <= CHAR_BITS; // RL7
		end else begin
			if (tx_step_fall) begin
				tx_sh <= io_mode ? {tx_sh[6:0], 1'b1} : {1'b1, tx_sh[7:1]}; // RL8 RL20
			end
			if (tx_step_rise) begin
				tx_cnt <= tx_cnt - 1'b1;
			end
			if (tx_done) begin
				tx_active <= 1'b0; // RL17
			end
		end
	end

	// Transmit line with mark level and mode-switch low pulse
	logic sw_to_rx;
	assign sw_to_rx = io_mode & txe_q & ~transmit_enable_bit & receive_enable_bit;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			txe_q <= 1'b0;
			low_cnt <= '0;
		end else begin
			txe_q <= transmit_enable_bit;
			if (sw_to_rx) begin
				low_cnt <= LOW_PULSE_CYC; // RL16
			end else if (low_cnt != '0) begin
				low_cnt <= low_cnt - 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			txd_o <= 1'b1;
		end else if (sw_to_rx || low_cnt > 6'h01) begin
			txd_o <= 1'b0; // RL16
		end else if (!transmit_enable_bit || (!tx_active && sck_o)) begin
			// Last bit holds until the pin clock has risen, so the peer samples it
			txd_o <= 1'b1; // RL21
		end else if (tx_step_fall) begin
			txd_o <= io_mode ? tx_sh[7] : tx_sh[0]; // RL8 RL20
		end
	end

	// Receive path
	logic rx_take, rx_store, search;
	logic [7:0] next_rx_sh;
	assign search = ~io_mode & se;
	assign rx_take = receive_enable_bit & rise_e; // RL1
	assign next_rx_sh = io_mode ? {rx_sh[6:0], pin_edge.rxd} : {pin_edge.rxd, rx_sh[7:1]};
	assign rx_store = rx_take & (search | rx_cnt == LAST_BIT_IDX); // RL2 RL4 RL13

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			rx_sh <= BYTE_RST;
			rxb <= BYTE_RST;
			rx_cnt <= 4'h0;
		end else begin
			if (rx_take) begin
				rx_sh <= next_rx_sh;
			end
			if (rx_store) begin
				rxb <= next_rx_sh; // RL2 RL4 RL13
			end
			// Search mode has no character boundary until software syncs
			if (search || rx_store) begin
				rx_cnt <= 4'h0; // RL3
			end else if (rx_take) begin
				rx_cnt <= rx_cnt + 1'b1;
			end
		end
	end

	// Receive burst runs until the remaining bits arrive
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			rx_run <= 1'b0;
		end else if (tsk_wr && io_mode && int_sel) begin
			rx_run <= 1'b1; // RL14 RL18
		end else if (rx_store || !io_mode || !int_sel) begin
			rx_run <= 1'b0;
		end
	end

	// Flags: hardware set wins over software clear
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			tx_req <= 1'b0;
			rx_req <= 1'b0;
			tx_flag <= 1'b0;
			rx_flag <= 1'b0;
		end else begin
			if (tx_load) begin
				tx_req <= 1'b1; // RL12
			end else if (wr_st && writedata_i[ST_TXREQ]) begin
				tx_req <= 1'b0;
			end
			if (rx_store) begin
				rx_req <= 1'b1;
			end else if (wr_st && writedata_i[ST_RXREQ]) begin
				rx_req <= 1'b0;
			end
			if (tx_done) begin
				tx_flag <= 1'b1; // RL17
			end else if (wr_tx || (wr_st && writedata_i[ST_TXF])) begin
				tx_flag <= 1'b0;
			end
			if (rx_store) begin
				rx_flag <= 1'b1; // RL18
			end else if (rd_rx || (wr_st && writedata_i[ST_RXF])) begin
				rx_flag <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			irq_tx_o <= 1'b0;
			irq_rx_o <= 1'b0;
		end else begin
			irq_tx_o <= tx_req & ~mask_tx; // RL12
			irq_rx_o <= rx_req & ~mask_rx; // RL5
		end
	end

	// Avalon slave: one wait cycle, then the answer
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			waitrequest_o <= 1'b1;
			readdata_o <= '0;
		end else if ((read_i || write_i) && waitrequest_o) begin
			waitrequest_o <= 1'b0;
			readdata_o <= '0;
			case (address_i)
				OFS_HMODE: readdata_o[4:0] <= {sk2, sk1, se, receive_enable_bit, transmit_enable_bit};
				OFS_LMODE: readdata_o[LM_IO] <= io_mode;
				OFS_MASK: readdata_o[1:0] <= {mask_tx, mask_rx};
				OFS_TXBUF: readdata_o[7:0] <= txb;
				OFS_RXBUF: readdata_o[7:0] <= rxb;
				OFS_STAT: readdata_o[5:0] <= {tx_active, tx_full, rx_flag, tx_flag, rx_req, tx_req};
				default: readdata_o <= '0;
			endcase
		end else begin
			waitrequest_o <= 1'b1;
		end
	end

	// Pulses within one internal I/O burst
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			burst_pulses <= 4'h0;
		end else if (!int_active) begin
			burst_pulses <= 4'h0;
		end else if (int_rise && io_mode) begin
			burst_pulses <= burst_pulses + 1'b1;
		end
	end

	property p_burst_len;
		@(posedge clk_sys_i) disable iff (rst_i)
		(int_rise && io_mode && !rx_run) |-> burst_pulses < CHAR_BITS;
	endproperty
	a_burst_len: assert property (p_burst_len) else $error("burst over eight pulses"); // RL9

	property p_mark;
		@(posedge clk_sys_i) disable iff (rst_i)
		(!transmit_enable_bit && low_cnt == '0 && !sw_to_rx) |=> txd_o;
	endproperty
	a_mark: assert property (p_mark) else $error("txd not at mark"); // RL21

	property p_rx_mask;
		@(posedge clk_sys_i) disable iff (rst_i)
		mask_rx |=> !irq_rx_o;
	endproperty
	a_rx_mask: assert property (p_rx_mask) else $error("masked rx irq seen"); // RL5

	property p_tx_irq;
		@(posedge clk_sys_i) disable iff (rst_i)
		(tx_load && !mask_tx) ##1 !mask_tx |=> irq_tx_o;
	endproperty
	a_tx_irq: assert property (p_tx_irq) else $error("tx irq missing after load"); // RL12

	property p_load_needs_txe;
		@(posedge clk_sys_i) disable iff (rst_i)
		$rose(tx_active) |-> $past(transmit_enable_bit) && !tx_full;
	endproperty
	a_load_needs_txe: assert property (p_load_needs_txe) else $error("load without txe"); // RL11

	property p_rx_gate;
		@(posedge clk_sys_i) disable iff (rst_i)
		!receive_enable_bit |=> $stable(rxb) && $stable(rx_sh);
	endproperty
	a_rx_gate: assert property (p_rx_gate) else $error("receive while disabled"); // RL1

	property p_search;
		@(posedge clk_sys_i) disable iff (rst_i)
		(rx_take && search) |=> rx_req && rx_flag && rxb == rx_sh;
	endproperty
	a_search: assert property (p_search) else $error("search bit not stored"); // RL2

	property p_char;
		@(posedge clk_sys_i) disable iff (rst_i)
		rx_store |-> (search || rx_cnt == LAST_BIT_IDX);
	endproperty
	a_char: assert property (p_char) else $error("store off character boundary"); // RL4

	property p_ext_clk;
		@(posedge clk_sys_i) disable iff (rst_i)
		(sk1 && sk2) |=> !sck_oe_o;
	endproperty
	a_ext_clk: assert property (p_ext_clk) else $error("driving sck with external clock"); // RL19

	property p_low_pulse;
		@(posedge clk_sys_i) disable iff (rst_i)
		sw_to_rx |=> !txd_o [*2];
	endproperty
	a_low_pulse: assert property (p_low_pulse) else $error("no low pulse on switch"); // RL16

	c_tx_done: cover property (@(posedge clk_sys_i) disable iff (rst_i) tx_done);
	c_rx_io: cover property (@(posedge clk_sys_i) disable iff (rst_i) rx_store && io_mode);
	c_search: cover property (@(posedge clk_sys_i) disable iff (rst_i) rx_store && search);
endmodule

// File: testbench/csx_peer.sv
// Partner model: external serial peer that shares the serial clock pin.
// Assumes the bench resolves the clock pin from both drivers into sck_line_i.
`timescale 1ns/1ps
module csx_peer (
	input wire logic sck_line_i,
	input wire logic txd_i,
	input wire logic go_i,
	input wire logic [3:0] pulses_i,
	input wire logic [7:0] send_i,
	output logic sck_o,
	output logic rxd_o,
	output logic busy_o,
	output logic done_o,
	output logic [7:0] got_o
);
	int k;
	int r;
	initial begin
		sck_o = 1'b1;
		rxd_o = 1'b0;
		busy_o = 1'b0;
		done_o = 1'b0;
		got_o = 8'h00;
		k = 0;
		r = 0;
	end
	// Long low phase so the block's delayed data settles before we sample
	always @(posedge go_i) begin
		busy_o = 1'b1;
		k = 0;
		r = 0;
		repeat (pulses_i) begin
			#5 sck_o = 1'b0;
			#125 sck_o = 1'b1;
			#70;
		end
		busy_o = 1'b0;
	end
	// Data out MSB first on the falling edge
	always @(negedge sck_line_i) begin
		rxd_o = send_i[7 - k];
		k = (k + 1) % 8;
	end
	// After the eighth rise the line is released: show the inverse
	always @(posedge sck_line_i) begin
		got_o = {got_o[6:0], txd_i};
		r = r + 1;
		if (r == 8) begin
			r = 0;
			done_o = ~done_o;
			#150 rxd_o = ~rxd_o;
		end
	end
endmodule

// File: testbench/tb_top.sv
// Self-checking bench for the clocked serial engine and its external peer.
// Assumes the register map and field positions of csx_pkg.
`timescale 1ns/1ps
module tb_top
	import csx_pkg::*;
;
	logic clk;
	logic rst;
	logic [ADDR_W-1:0] address;
	logic read_r;
	logic write_r;
	logic [31:0] writedata;
	logic [31:0] readdata;
	logic waitrequest;
	logic sck_drv;
	logic sck_oe;
	logic txd;
	logic irq_tx;
	logic irq_rx;
	logic pr_sck;
	logic pr_rxd;
	logic pr_busy;
	logic pr_done;
	logic pr_go;
	logic [3:0] pr_n;
	logic [7:0] pr_tx;
	logic [7:0] pr_got;
	logic sck_line;
	logic probe;
	logic seen = 1'b0;
	logic [31:0] expq[$];
	int bad_count = 0;
	int checks_done = 0;
	int cyc = 0;
	logic [7:0] b;
	logic [7:0] rv;
	// Unknown enable at time zero must not fake a clock edge
	assign sck_line = (sck_oe === 1'b1) ? sck_drv : pr_sck;
	csx_serial DUT (.clk_sys_i(clk), .rst_i(rst), .address_i(address), .read_i(read_r),
		.write_i(write_r), .writedata_i(writedata), .readdata_o(readdata),
		.waitrequest_o(waitrequest), .sck_i(sck_line), .rxd_i(pr_rxd), .sck_o(sck_drv),
		.sck_oe_o(sck_oe), .txd_o(txd), .irq_tx_o(irq_tx), .irq_rx_o(irq_rx));
	csx_peer partner (.sck_line_i(sck_line), .txd_i(txd), .go_i(pr_go), .pulses_i(pr_n),
		.send_i(pr_tx), .sck_o(pr_sck), .rxd_o(pr_rxd), .busy_o(pr_busy), .done_o(pr_done),
		.got_o(pr_got));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task final_report;
		$display("checks %0d errors %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task got(input logic [31:0] v);
		logic [31:0] e;
		e = 32'hxxxx_xxxx;
		if (expq.size() > 0)
			e = expq.pop_front();
		checks_done++;
		if (v !== e) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, v, e);
		end
	endtask
	// Watcher: every result takes the oldest note
	always @(posedge clk) begin
		seen <= pr_done;
		if (read_r && waitrequest === 1'b0)
			got(readdata);
		if (probe)
			got({28'h000_0000, irq_rx, irq_tx, sck_drv, txd});
		if (pr_done !== seen)
			got({24'h00_0000, pr_got});
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			final_report();
		end
	end
	task bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int n;
		n = 0;
		address <= a;
		writedata <= d;
		write_r <= w;
		read_r <= ~w;
		@(posedge clk);
		while (waitrequest !== 1'b0 && n < 100) begin
			@(posedge clk);
			n++;
		end
		if (n == 100)
			bad_count++;
		write_r <= 1'b0;
		read_r <= 1'b0;
		@(posedge clk);
	endtask
	task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
		expq.push_back(e);
		bus(1'b0, a, 32'h0000_0000);
	endtask
	task pin(input logic [3:0] e);
		expq.push_back({28'h000_0000, e});
		probe <= 1'b1;
		@(posedge clk);
		probe <= 1'b0;
		@(posedge clk);
	endtask
	task frame(input logic [3:0] n, input logic [7:0] v);
		int m;
		m = 0;
		pr_n <= n;
		pr_tx <= v;
		pr_go <= 1'b1;
		@(posedge clk);
		pr_go <= 1'b0;
		repeat (2) @(posedge clk);
		while (pr_busy === 1'b1 && m < 1000) begin
			@(posedge clk);
			m++;
		end
		repeat (12) @(posedge clk);
	endtask
	task waitdone;
		logic s0;
		int m;
		s0 = pr_done;
		m = 0;
		while (pr_done === s0 && m < 3000) begin
			@(posedge clk);
			m++;
		end
		if (m == 3000)
			bad_count++;
		repeat (8) @(posedge clk);
	endtask
	function automatic logic [7:0] rev(input logic [7:0] x);
		logic [7:0] y;
		for (int i = 0; i < 8; i++)
			y[i] = x[7 - i];
		return y;
	endfunction
	initial begin
		rst = 1'b1;
		read_r = 1'b0;
		write_r = 1'b0;
		address = '0;
		writedata = 32'h0000_0000;
		probe = 1'b0;
		pr_go = 1'b0;
		pr_n = 4'h0;
		pr_tx = 8'h00;
		void'($urandom(9));
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(OFS_HMODE, 32'h0000_0000);
		rd(OFS_MASK, 32'h0000_0003);
		rd(5'h18, 32'h0000_0000);
		pin(4'b0011);
		// Internal clock transmit in I/O mode
		wr(OFS_LMODE, 32'h0000_0001);
		wr(OFS_MASK, 32'h0000_0001);
		wr(OFS_HMODE, 32'h0000_0009);
		wr(OFS_STAT, 32'h0000_000f);
		// Zero-pulse frame clears the peer's bit counts after a start-up edge
		frame(4'h0, 8'h00);
		b = 8'($urandom);
		expq.push_back({24'h00_0000, b});
		wr(OFS_TXBUF, {24'h00_0000, b});
		waitdone();
		pin(4'b0111);
		rd(OFS_STAT, 32'h0000_0005);
		wr(OFS_MASK, 32'h0000_0003);
		pin(4'b0011);
		wr(OFS_HMODE, 32'h0000_001a);
		pin(4'b0010);
		repeat (40) @(posedge clk);
		pin(4'b0011);
		for (int i = 0; i < 2; i++) begin
			wr(OFS_STAT, 32'h0000_000f);
			b = 8'($urandom);
			expq.push_back(32'h0000_00ff);
			frame(4'h8, b);
			pin(4'b0011);
			wr(OFS_MASK, 32'h0000_0002);
			pin(4'b1011);
			rd(OFS_RXBUF, {24'h00_0000, b});
			wr(OFS_MASK, 32'h0000_0003);
		end
		// Short external frame, finished on the internal clock
		b = 8'($urandom);
		frame(4'h5, b);
		wr(OFS_HMODE, 32'h0000_000a);
		repeat (100) @(posedge clk);
		pin(4'b0011);
		expq.push_back(32'h0000_00ff);
		wr(OFS_HMODE, 32'h0000_002a);
		waitdone();
		rd(OFS_RXBUF, {24'h00_0000, b});
		// Synchronous mode: leave internal clock first, it free-runs there
		wr(OFS_HMODE, 32'h0000_001a);
		wr(OFS_LMODE, 32'h0000_0000);
		b = 8'($urandom);
		rv = rev(b);
		expq.push_back(32'h0000_00ff);
		frame(4'h8, b);
		rd(OFS_RXBUF, {24'h00_0000, rv});
		wr(OFS_HMODE, 32'h0000_001e);
		b = 8'($urandom);
		frame(4'h1, b);
		rv = {b[7], rv[7:1]};
		rd(OFS_RXBUF, {24'h00_0000, rv});
		wr(OFS_HMODE, 32'h0000_0018);
		expq.push_back(32'h0000_00ff);
		frame(4'h8, 8'($urandom));
		rd(OFS_RXBUF, {24'h00_0000, rv});
		wr(OFS_HMODE, 32'h0000_0019);
		b = 8'($urandom);
		expq.push_back({24'h00_0000, rev(b)});
		wr(OFS_TXBUF, {24'h00_0000, b});
		repeat (4) @(posedge clk);
		frame(4'h8, 8'h00);
		repeat (4) @(posedge clk);
		final_report();
	end
endmodule
